// *** design/elrb_defines.vh ***
// Constants for the event log record builder
`ifndef ELRB_DEFINES_VH
`define ELRB_DEFINES_VH

// Log register map
`define ELRB_NUM_RECORDS_ADDR      16'h4E20
`define ELRB_RECENT_RECORD_ADDR    16'h4E21
`define ELRB_REC1_SEQUENCE_NUMBER  16'h4E22
`define ELRB_REC1_TIME_STAMP       16'h4E23
`define ELRB_REC1_IDENTIFIER       16'h4E27
`define ELRB_REC1_VALUE_FIELD      16'h4E29
`define ELRB_REC1_EVENT_PAIR_ID    16'h4E2D
`define ELRB_REC2_SEQUENCE_NUMBER  16'h4E2E
`define ELRB_REC2_TIME_STAMP       16'h4E2F
`define ELRB_REC2_IDENTIFIER       16'h4E33
`define ELRB_REC2_VALUE_FIELD      16'h4E35
`define ELRB_REC2_EVENT_PAIR_ID    16'h4E39

// Word positions inside one record, derived from the map
`define ELRB_REC_STRIDE  (`ELRB_REC2_SEQUENCE_NUMBER - `ELRB_REC1_SEQUENCE_NUMBER)
`define ELRB_W_SEQ       (`ELRB_REC1_SEQUENCE_NUMBER - `ELRB_REC1_SEQUENCE_NUMBER)
`define ELRB_W_TIME      (`ELRB_REC1_TIME_STAMP - `ELRB_REC1_SEQUENCE_NUMBER)
`define ELRB_W_IDENT     (`ELRB_REC1_IDENTIFIER - `ELRB_REC1_SEQUENCE_NUMBER)
`define ELRB_W_VALUE     (`ELRB_REC1_VALUE_FIELD - `ELRB_REC1_SEQUENCE_NUMBER)
`define ELRB_W_PAIR      (`ELRB_REC1_EVENT_PAIR_ID - `ELRB_REC1_SEQUENCE_NUMBER)

// Record identifier codes
`define ELRB_ROLE_PRIMARY     8'h01
`define ELRB_ROLE_SECONDARY   8'h00
`define ELRB_TYPE_FLOAT32     8'h40
`define ELRB_TYPE_UINT16      8'h10
`define ELRB_SRC_RESISTANCE   16'h03E8
`define ELRB_SRC_ALARM_STATUS 16'h044C

// Numbering reset values and steps
`define ELRB_SEQ_FIRST        16'h0001
`define ELRB_PAIR_FIRST       16'h0001
`define ELRB_PAIR_STEP        16'h0002
`define ELRB_PAIR_SEC_OFFSET  16'h0001
`define ELRB_PAIR_LAST        16'hFFFD

// Time stamp field positions
`define ELRB_YEAR_LSB         0
`define ELRB_RESERVED_BIT     7
`define ELRB_MONTH_LSB        8
`define ELRB_WEEKDAY_LSB      5
`define ELRB_DAY_LSB          0
`define ELRB_SUMMER_BIT       15
`define ELRB_HOUR_LSB         8
`define ELRB_INVALID_BIT      7
`define ELRB_MINUTE_LSB       0

// Time stamp field limits
`define ELRB_MONTH_MIN        4'h1
`define ELRB_MONTH_MAX        4'hC
`define ELRB_DAY_MIN          5'h01
`define ELRB_HOUR_MAX         5'h17
`define ELRB_MINUTE_MAX       6'h3B
`define ELRB_MSEC_MAX         16'hEA5F

`endif

// *** design/elrb_time_encoder.v ***
// Packs date and time fields into the four-word binary time stamp
`timescale 1ns/10ps
`default_nettype none
`include "elrb_defines.vh"

module elrb_time_encoder (
  // Date fields
  input  wire [6:0]  year_in,
  input  wire [3:0]  month_in,
  input  wire [2:0]  weekday_field_in,
  input  wire [4:0]  day_in,
  // Time fields
  input  wire        summertime_flag_in,
  input  wire [4:0]  hour_in,
  input  wire        invalid_time_flag_in,
  input  wire [5:0]  minute_field_in,
  input  wire [15:0] millisecond_field_in,
  // Packed stamp, word 1 in the top bits
  output reg  [63:0] stamp_out
);

  reg [15:0] word1;
  reg [15:0] word2;
  reg [15:0] word3;
  reg        out_of_range;

  always @* begin
    // Any field outside its range marks the stamp as not valid
    out_of_range = (month_in < `ELRB_MONTH_MIN) || (month_in > `ELRB_MONTH_MAX) ||
                   (day_in < `ELRB_DAY_MIN) || (hour_in > `ELRB_HOUR_MAX) ||
                   (minute_field_in > `ELRB_MINUTE_MAX) || (millisecond_field_in > `ELRB_MSEC_MAX);
    // Unlisted bits start at zero and only named fields are filled
    word1 = 16'h0000;
    word2 = 16'h0000;
    word3 = 16'h0000;
    word1[`ELRB_YEAR_LSB +: 7] = year_in;
    word1[`ELRB_RESERVED_BIT] = 1'b0;
    word2[`ELRB_MONTH_LSB +: 4] = month_in;
    word2[`ELRB_WEEKDAY_LSB +: 3] = weekday_field_in;
    word2[`ELRB_DAY_LSB +: 5] = day_in;
    word3[`ELRB_SUMMER_BIT] = summertime_flag_in;
    word3[`ELRB_HOUR_LSB +: 5] = hour_in;
    word3[`ELRB_INVALID_BIT] = invalid_time_flag_in | out_of_range;
    word3[`ELRB_MINUTE_LSB +: 6] = minute_field_in;
    // Fields are plain binary, no BCD conversion
    stamp_out = {word1, word2, word3, millisecond_field_in};
  end

endmodule

`default_nettype wire

// *** design/elrb_record_builder.v ***
// Event log record builder with its read-only record store
`timescale 1ns/10ps
`default_nettype none
`include "elrb_defines.vh"

module elrb_record_builder #(
  parameter LOG_RECORDS = 60,
  parameter SLOT_W      = 6,
  parameter CNT_W       = 7,
  parameter IDX_W       = 10
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // Alarm event source
  input  wire        alarm_active_in,
  input  wire [31:0] resistance_in,
  input  wire [15:0] alarm_type_in,
  // Current date and time
  input  wire [6:0]  year_in,
  input  wire [3:0]  month_in,
  input  wire [2:0]  weekday_field_in,
  input  wire [4:0]  day_in,
  input  wire        summertime_flag_in,
  input  wire [4:0]  hour_in,
  input  wire        invalid_time_flag_in,
  input  wire [5:0]  minute_field_in,
  input  wire [15:0] millisecond_field_in,
  // Register read port
  input  wire        rd_en_in,
  input  wire [15:0] rd_addr_in,
  output reg  [15:0] rd_data_out,
  output reg         rd_valid_out,
  output reg         rd_error_out,
  // Status
  output reg         busy_out,
  output reg         record_done_out
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_WRITE = 2'b01;

  localparam integer MEM_WORDS    = LOG_RECORDS * `ELRB_REC_STRIDE;
  // Full-width copies, cut to their target width on purpose below
  localparam [31:0]  MEM_WORDS_W  = MEM_WORDS;
  localparam [31:0]  RECORDS_W    = LOG_RECORDS;
  localparam [31:0]  LAST_SLOT_W  = LOG_RECORDS - 1;
  localparam [15:0]  STRIDE_W     = `ELRB_REC_STRIDE;
  localparam [15:0]  LOG_SPAN     = MEM_WORDS_W[15:0];
  localparam [CNT_W-1:0] FULL_CNT = RECORDS_W[CNT_W-1:0];
  localparam [SLOT_W-1:0] LAST_SLOT = LAST_SLOT_W[SLOT_W-1:0];
  localparam [3:0]   LAST_WORD    = STRIDE_W[3:0] - 4'h1;

  // Record store
  reg [15:0] mem [0:MEM_WORDS-1];

  // Event capture
  reg        alarm_prev;
  reg        pend_pri;
  reg        pend_sec;
  reg [63:0] pri_stamp;
  reg [31:0] pri_value;
  reg [63:0] sec_stamp;
  reg [15:0] sec_type;

  // Builder state
  reg [1:0]        state;
  reg [3:0]        word_cnt;
  reg              cur_primary;
  reg [63:0]       cur_stamp;
  reg [31:0]       cur_value;
  reg [15:0]       cur_pair;
  reg [15:0]       seq_num;
  reg [15:0]       last_pri_id;
  reg              have_primary;
  reg              last_was_primary;
  reg [SLOT_W-1:0] wr_slot;
  reg [CNT_W-1:0]  filled;
  reg [15:0]       recent_num;

  // Time stamp, event edges, write control and read decode
  wire [63:0] now_stamp;
  wire [15:0] rd_off;
  wire [15:0] rd_quot;
  wire [15:0] rd_rem;
  wire        rd_in_log;
  wire        rd_slot_shown;
  wire        start_pri;
  wire        start_sec;
  wire        last_write;
  wire        alarm_rise;
  wire        alarm_fall;

  elrb_time_encoder u_time_encoder (
    .year_in              (year_in),
    .month_in             (month_in),
    .weekday_field_in     (weekday_field_in),
    .day_in               (day_in),
    .summertime_flag_in   (summertime_flag_in),
    .hour_in              (hour_in),
    .invalid_time_flag_in (invalid_time_flag_in),
    .minute_field_in      (minute_field_in),
    .millisecond_field_in (millisecond_field_in),
    .stamp_out            (now_stamp)
  );

  // Flat store index of one word of one slot
  function [IDX_W-1:0] mem_index;
    input [SLOT_W-1:0] slot;
    input [3:0]        word;
    reg   [15:0]       tmp;
    begin
      tmp = {{(16-SLOT_W){1'b0}}, slot} * `ELRB_REC_STRIDE + {12'h000, word};
      mem_index = tmp[IDX_W-1:0];
    end
  endfunction

  // Content of one record word
  function [15:0] record_word;
    input [3:0]  word;
    input        primary;
    input [63:0] stamp;
    input [31:0] value;
    input [15:0] seq;
    input [15:0] pair;
    reg   [15:0] w;
    begin
      w = {12'h000, word};
      record_word = 16'h0000;
      if (w == `ELRB_W_SEQ) begin
        record_word = seq;
      end else if (w == `ELRB_W_TIME) begin
        record_word = stamp[63:48];
      end else if (w == `ELRB_W_TIME + 16'h0001) begin
        record_word = stamp[47:32];
      end else if (w == `ELRB_W_TIME + 16'h0002) begin
        record_word = stamp[31:16];
      end else if (w == `ELRB_W_TIME + 16'h0003) begin
        record_word = stamp[15:0];
      end else if (w == `ELRB_W_IDENT) begin
        record_word = primary ? {`ELRB_ROLE_PRIMARY, `ELRB_TYPE_FLOAT32}
                              : {`ELRB_ROLE_SECONDARY, `ELRB_TYPE_UINT16};
      end else if (w == `ELRB_W_IDENT + 16'h0001) begin
        record_word = primary ? `ELRB_SRC_RESISTANCE : `ELRB_SRC_ALARM_STATUS;
      end else if (w == `ELRB_W_VALUE + 16'h0002) begin
        // Secondary values carry zero here, the type lives in the last word
        record_word = value[31:16];
      end else if (w == `ELRB_W_VALUE + 16'h0003) begin
        record_word = value[15:0];
      end else if (w == `ELRB_W_PAIR) begin
        record_word = pair;
      end
    end
  endfunction

  // Next primary pair id; wraps early so the secondary id never leaves 1..65534
  function [15:0] next_pair_id;
    input        have_prev;
    input [15:0] prev;
    begin
      if (!have_prev || prev >= `ELRB_PAIR_LAST) begin
        next_pair_id = `ELRB_PAIR_FIRST;
      end else begin
        next_pair_id = prev + `ELRB_PAIR_STEP;
      end
    end
  endfunction

  // Record number after the given one; zero is skipped on wrap so numbering stays 1 and up
  function [15:0] next_seq_num;
    input [15:0] seq;
    begin
      if (seq == 16'hFFFF) begin
        next_seq_num = `ELRB_SEQ_FIRST;
      end else begin
        next_seq_num = seq + 16'h0001;
      end
    end
  endfunction

  // Slot after the given one; the oldest slot is reused once the log is full
  function [SLOT_W-1:0] next_slot;
    input [SLOT_W-1:0] slot;
    begin
      if (slot == LAST_SLOT) begin
        next_slot = {SLOT_W{1'b0}};
      end else begin
        next_slot = slot + {{(SLOT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  assign alarm_rise = alarm_active_in & ~alarm_prev;
  assign alarm_fall = ~alarm_active_in & alarm_prev;

  // Records alternate so the two records of one event land in neighbouring slots
  assign start_sec = (state == ST_IDLE) && pend_sec && last_was_primary;
  assign start_pri = (state == ST_IDLE) && pend_pri && !last_was_primary;
  assign last_write = (state == ST_WRITE) && (word_cnt == LAST_WORD);

  assign rd_off    = rd_addr_in - `ELRB_REC1_SEQUENCE_NUMBER;
  assign rd_quot   = rd_off / `ELRB_REC_STRIDE;
  assign rd_rem    = rd_off % `ELRB_REC_STRIDE;
  assign rd_in_log = (rd_addr_in >= `ELRB_REC1_SEQUENCE_NUMBER) && (rd_off < LOG_SPAN);
  // The slot under construction stays hidden even when it was full before
  assign rd_slot_shown = ({{(16-CNT_W){1'b0}}, filled} > rd_quot) &&
                         !(busy_out && (rd_quot[SLOT_W-1:0] == wr_slot));

  // Event capture: set beats a clear in the same cycle
  always @(posedge clk_in) begin
    if (reset_in) begin
      alarm_prev <= 1'b0;
      pend_pri   <= 1'b0;
      pend_sec   <= 1'b0;
      pri_stamp  <= 64'h0000000000000000;
      pri_value  <= 32'h00000000;
      sec_stamp  <= 64'h0000000000000000;
      sec_type   <= 16'h0000;
    end else begin
      alarm_prev <= alarm_active_in;
      if (alarm_rise) begin
        // Snapshot at the moment of the event, not when the record is written
        pend_pri  <= 1'b1;
        pri_stamp <= now_stamp;
        pri_value <= resistance_in;
      end else if (start_pri) begin
        pend_pri <= 1'b0;
      end
      if (alarm_fall) begin
        pend_sec  <= 1'b1;
        sec_stamp <= now_stamp;
        sec_type  <= alarm_type_in;
      end else if (start_sec) begin
        pend_sec <= 1'b0;
      end
    end
  end

  // Record writer: one word per cycle, published only after the last word
  always @(posedge clk_in) begin
    if (reset_in) begin
      state            <= ST_IDLE;
      word_cnt         <= 4'h0;
      cur_primary      <= 1'b0;
      cur_stamp        <= 64'h0000000000000000;
      cur_value        <= 32'h00000000;
      cur_pair         <= 16'h0000;
      seq_num          <= `ELRB_SEQ_FIRST;
      last_pri_id      <= 16'h0000;
      have_primary     <= 1'b0;
      last_was_primary <= 1'b0;
      wr_slot          <= {SLOT_W{1'b0}};
      filled           <= {CNT_W{1'b0}};
      recent_num       <= 16'h0000;
      busy_out         <= 1'b0;
      record_done_out  <= 1'b0;
    end else begin
      record_done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          word_cnt <= 4'h0;
          if (start_sec) begin
            cur_primary <= 1'b0;
            cur_stamp   <= sec_stamp;
            cur_value   <= {16'h0000, sec_type};
            cur_pair    <= last_pri_id + `ELRB_PAIR_SEC_OFFSET;
            busy_out    <= 1'b1;
            state       <= ST_WRITE;
          end else if (start_pri) begin
            cur_primary <= 1'b1;
            cur_stamp   <= pri_stamp;
            cur_value   <= pri_value;
            cur_pair    <= next_pair_id(have_primary, last_pri_id);
            busy_out    <= 1'b1;
            state       <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          word_cnt <= word_cnt + 4'h1;
          if (last_write) begin
            // Commit: the record becomes readable from the next cycle
            state            <= ST_IDLE;
            busy_out         <= 1'b0;
            record_done_out  <= 1'b1;
            recent_num       <= seq_num;
            seq_num          <= next_seq_num(seq_num);
            last_was_primary <= cur_primary;
            if (cur_primary) begin
              last_pri_id  <= cur_pair;
              have_primary <= 1'b1;
            end
            if (filled != FULL_CNT) begin
              filled <= filled + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            wr_slot <= next_slot(wr_slot);
          end
        end
        default: begin
          state    <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Store write port, no reset on the array
  always @(posedge clk_in) begin
    if (!reset_in && state == ST_WRITE) begin
      mem[mem_index(wr_slot, word_cnt)] <= record_word(word_cnt, cur_primary, cur_stamp,
                                                       cur_value, seq_num, cur_pair);
    end
  end

  // Read port: answers one cycle after the request, never writes
  always @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_out  <= 16'h0000;
      rd_valid_out <= 1'b0;
      rd_error_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      rd_error_out <= 1'b0;
      if (rd_en_in) begin
        rd_data_out <= 16'h0000;
        if (rd_addr_in == `ELRB_NUM_RECORDS_ADDR) begin
          rd_data_out <= {{(16-CNT_W){1'b0}}, filled};
        end else if (rd_addr_in == `ELRB_RECENT_RECORD_ADDR) begin
          rd_data_out <= recent_num;
        end else if (rd_in_log) begin
          // Empty or unfinished slots read as zero
          if (rd_slot_shown) begin
            rd_data_out <= mem[mem_index(rd_quot[SLOT_W-1:0], rd_rem[3:0])];
          end
        end else begin
          rd_error_out <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** verification/elrb_master_model.sv ***
// Register-reading master model for the record log
`timescale 1ns/10ps
`default_nettype none
module elrb_master_model (
  // Clock
  input  wire logic        clk_in,
  // Read request
  output var  logic        rd_en_out,
  output var  logic [15:0] rd_addr_out,
  // Read answer
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic        rd_error_in
);
  initial begin
    rd_en_out = 1'b0;
    rd_addr_out = 16'h0000;
  end
  // Reads only; the log offers no write path
  task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic e, output logic ok);
    int i;
    ok = 1'b0;
    d = 16'h0000;
    e = 1'b0;
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    rd_addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    // Inverse address after release, so a stale address is never taken for a held one
    rd_addr_out <= ~a;
    for (i = 0; i < 3 && !ok; i++) begin
      @(posedge clk_in);
      if (rd_valid_in === 1'b1) begin
        ok = 1'b1;
        d = rd_data_in;
        e = rd_error_in;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** verification/elrb_record_builder_properties.sv ***
// Port-level properties of the event log record builder
`timescale 1ns/10ps
`default_nettype none
module elrb_record_builder_properties #(
  parameter LOG_RECORDS = 60
) (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        alarm_active_in,
  input wire logic        rd_en_in,
  input wire logic [15:0] rd_addr_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        rd_valid_out,
  input wire logic        rd_error_out,
  input wire logic        busy_out,
  input wire logic        record_done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_read_answered: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered");
  a_no_stray_answer: assert property (!rd_en_in |=> !rd_valid_out && !rd_error_out)
    else $error("answer without read");
  a_low_unmapped: assert property (rd_en_in && rd_addr_in < 16'h4E20
    |=> rd_error_out && rd_data_out == 16'h0000)
    else $error("low address not refused");
  a_high_unmapped: assert property (rd_en_in && rd_addr_in > 16'h4E21 + LOG_RECORDS * 12 |=> rd_error_out)
    else $error("high address not refused");
  a_mapped_accepted: assert property (rd_en_in && rd_addr_in >= 16'h4E20
    && rd_addr_in <= 16'h4E21 + LOG_RECORDS * 12 |=> !rd_error_out)
    else $error("mapped address refused");
  a_count_bounded: assert property (rd_en_in && rd_addr_in == 16'h4E20 |=> rd_data_out <= LOG_RECORDS)
    else $error("record count too large");
  a_data_holds: assert property (!rd_valid_out |-> $stable(rd_data_out))
    else $error("read data moved without a read");
  a_write_length: assert property ($rose(busy_out) |-> busy_out [*8] ##1 busy_out [*4]
    ##1 (record_done_out && !busy_out))
    else $error("record write length wrong");
  a_commit_ends_busy: assert property (record_done_out |-> !busy_out && $past(busy_out))
    else $error("commit not at end of write");
  a_event_starts: assert property ($changed(alarm_active_in) && !busy_out && !record_done_out
    |-> ##[1:3] busy_out)
    else $error("event did not start a record");
  cover property ($rose(record_done_out));
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the event log record builder
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        alarm_active_in = 1'b0;
  logic [31:0] resistance_in = 32'h00000000;
  logic [15:0] alarm_type_in = 16'h0000;
  logic [6:0]  year_in = 7'h00;
  logic [3:0]  month_in = 4'h1;
  logic [2:0]  weekday_field_in = 3'h0;
  logic [4:0]  day_in = 5'h01;
  logic        summertime_flag_in = 1'b0;
  logic [4:0]  hour_in = 5'h00;
  logic        invalid_time_flag_in = 1'b0;
  logic [5:0]  minute_field_in = 6'h00;
  logic [15:0] millisecond_field_in = 16'h0000;
  wire         rd_en_in;
  wire  [15:0] rd_addr_in;
  wire  [15:0] rd_data_out;
  wire         rd_valid_out;
  wire         rd_error_out;
  wire         busy_out;
  wire         record_done_out;
  int          num_errors = 0;
  int          total_checks = 0;
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  elrb_record_builder u_dut (.clk_in(clk_in), .reset_in(reset_in), .alarm_active_in(alarm_active_in),
    .resistance_in(resistance_in), .alarm_type_in(alarm_type_in), .year_in(year_in), .month_in(month_in),
    .weekday_field_in(weekday_field_in), .day_in(day_in), .summertime_flag_in(summertime_flag_in),
    .hour_in(hour_in), .invalid_time_flag_in(invalid_time_flag_in), .minute_field_in(minute_field_in),
    .millisecond_field_in(millisecond_field_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .rd_error_out(rd_error_out),
    .busy_out(busy_out), .record_done_out(record_done_out));
  elrb_master_model u_master (.clk_in(clk_in), .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in),
    .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out), .rd_error_in(rd_error_out));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp, input logic xe);
    logic [15:0] d;
    logic        e;
    logic        ok;
    u_master.read_word(a, d, e, ok);
    chk({what, " answered"}, {15'h0000, ok}, 16'h0001);
    chk(what, d, exp);
    chk({what, " error"}, {15'h0000, e}, {15'h0000, xe});
  endtask
  // Stamp layout: word 1 in the top bits; inputs are sliced out of the expected stamp
  task automatic set_time(input logic [63:0] s);
    year_in <= s[54:48];
    month_in <= s[43:40];
    weekday_field_in <= s[39:37];
    day_in <= s[36:32];
    summertime_flag_in <= s[31];
    hour_in <= s[28:24];
    invalid_time_flag_in <= s[23];
    minute_field_in <= s[21:16];
    millisecond_field_in <= s[15:0];
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 40 && record_done_out !== 1'b1; i++) @(posedge clk_in);
    chk("record committed", {15'h0000, record_done_out}, 16'h0001);
    @(posedge clk_in);
  endtask
  // Sequence and pairing ids coincide while records alternate from reset
  task automatic chk_rec(input int k, input logic p, input logic [63:0] s, input logic [31:0] v);
    logic [15:0] q;
    logic [15:0] w [12];
    logic [15:0] b;
    int          i;
    q = p ? 16'(2 * k - 1) : 16'(2 * k);
    w = '{q, s[63:48], s[47:32], s[31:16], s[15:0], p ? 16'h0140 : 16'h0010,
          p ? 16'h03E8 : 16'h044C, 16'h0000, 16'h0000, v[31:16], v[15:0], q};
    b = 16'h4E22 + (q - 16'h0001) * 16'h000C;
    for (i = 0; i < 12; i++) begin
      rd_chk("record word", b + 16'(i), w[i], 1'b0);
    end
  endtask
  task automatic t_empty();
    rd_chk("count", 16'h4E20, 16'h0000, 1'b0);
    rd_chk("latest", 16'h4E21, 16'h0000, 1'b0);
    rd_chk("empty slot", 16'h4E22, 16'h0000, 1'b0);
    $display("t_empty done");
  endtask
  task automatic t_event1();
    @(posedge clk_in);
    set_time(64'h000A_0A01_0C00_0000);
    resistance_in <= 32'h461C4000;
    alarm_active_in <= 1'b1;
    wait_done();
    chk_rec(1, 1'b1, 64'h000A_0A01_0C00_0000, 32'h461C4000);
    @(posedge clk_in);
    set_time(64'h000A_0A01_0C1D_0000);
    resistance_in <= 32'hFFFFFFFF;
    alarm_type_in <= 16'h0008;
    alarm_active_in <= 1'b0;
    // Land the read after the first words of the record are already in the store
    repeat (4) @(posedge clk_in);
    rd_chk("slot while writing", 16'h4E2E, 16'h0000, 1'b0);
    wait_done();
    chk_rec(1, 1'b0, 64'h000A_0A01_0C1D_0000, 32'h00000008);
    rd_chk("count", 16'h4E20, 16'h0002, 1'b0);
    rd_chk("latest", 16'h4E21, 16'h0002, 1'b0);
    $display("t_event1 done");
  endtask
  // Fall one cycle after rise: secondary must queue behind the primary
  task automatic t_event2();
    @(posedge clk_in);
    set_time(64'h007F_0CFF_97BB_EA5F);
    resistance_in <= 32'h3F800000;
    alarm_active_in <= 1'b1;
    @(posedge clk_in);
    set_time(64'h0000_0121_0000_0000);
    resistance_in <= 32'h00000000;
    alarm_type_in <= 16'h0004;
    alarm_active_in <= 1'b0;
    wait_done();
    wait_done();
    chk_rec(2, 1'b1, 64'h007F_0CFF_97BB_EA5F, 32'h3F800000);
    chk_rec(2, 1'b0, 64'h0000_0121_0000_0000, 32'h00000004);
    rd_chk("count", 16'h4E20, 16'h0004, 1'b0);
    rd_chk("latest", 16'h4E21, 16'h0004, 1'b0);
    $display("t_event2 done");
  endtask
  task automatic t_map();
    rd_chk("below map", 16'h4E1F, 16'h0000, 1'b1);
    rd_chk("past map", 16'h50F2, 16'h0000, 1'b1);
    rd_chk("last word", 16'h50F1, 16'h0000, 1'b0);
    rd_chk("next slot", 16'h4E52, 16'h0000, 1'b0);
    $display("t_map done");
  endtask
  // Out-of-range fields are kept as given and force the invalid bit
  task automatic t_event3();
    @(posedge clk_in);
    set_time(64'h0014_0D01_0C00_0000);
    resistance_in <= 32'h447A0000;
    alarm_active_in <= 1'b1;
    wait_done();
    @(posedge clk_in);
    set_time(64'h0014_0C1F_173C_0000);
    alarm_type_in <= 16'h0002;
    alarm_active_in <= 1'b0;
    wait_done();
    chk_rec(3, 1'b1, 64'h0014_0D01_0C80_0000, 32'h447A0000);
    chk_rec(3, 1'b0, 64'h0014_0C1F_17BC_0000, 32'h00000002);
    rd_chk("count", 16'h4E20, 16'h0006, 1'b0);
    $display("t_event3 done");
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    t_empty();
    t_event1();
    t_event2();
    t_map();
    t_event3();
    conclude();
  end
endmodule
bind elrb_record_builder elrb_record_builder_properties #(.LOG_RECORDS(LOG_RECORDS)) u_props (
  .clk_in(clk_in), .reset_in(reset_in), .alarm_active_in(alarm_active_in), .rd_en_in(rd_en_in),
  .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .rd_error_out(rd_error_out), .busy_out(busy_out), .record_done_out(record_done_out));
`default_nettype wire
